//--- ihbp_pkg.sv
package ihbp_pkg;

  // register byte offsets on the apb side
  localparam logic [7:0] OFS_CONFIG   = 8'h00;
  localparam logic [7:0] OFS_MEM_BASE = 8'h04;
  localparam logic [7:0] OFS_IO_BASE  = 8'h08;
  localparam logic [7:0] OFS_RAM_PTR  = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_ADDR     = 8'h14;

  // configuration field positions
  localparam int CFG_WIDE_BIT   = 7;
  localparam int CFG_DECODE_BIT = 5;
  localparam int CFG_WAIT_BIT   = 4;

  // widths of the host-side fields
  localparam int MEM_BASE_W = 9;
  localparam int IO_BASE_W  = 14;
  localparam int RAM_PTR_W  = 11;
  localparam int EVT_W      = 2;

  // reset values
  localparam logic            CFG_WIDE_RST   = 1'b0;
  localparam logic            CFG_DECODE_RST = 1'b0;
  localparam logic            CFG_WAIT_RST   = 1'b1;
  localparam logic [8:0]      MEM_BASE_RST   = 9'h1A0;
  localparam logic [13:0]     IO_BASE_RST    = 14'h00B8;
  localparam logic [10:0]     RAM_PTR_RST    = 11'h000;

  // data-port pointer steps
  localparam logic [10:0] STEP_WIDE   = 11'h002;
  localparam logic [10:0] STEP_NARROW = 11'h001;

  // timing
  localparam int CLK_MHZ             = 100;
  localparam int TX_LED_US           = 314;
  localparam int TX_LED_CYCLES       = TX_LED_US * CLK_MHZ;
  localparam int XTAL_DIV_DEF        = 5;
  localparam int READY_TICKS_LATER   = 3;
  localparam int READY_TICKS_EARLIER = 2;

  // strobe vector index
  localparam int STB_MEMR = 0;
  localparam int STB_MEMW = 1;
  localparam int STB_IOR  = 2;
  localparam int STB_IOW  = 3;
  localparam int STB_N    = 4;

  // apb slave state
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ACK  = 2'b10
  } ihbp_apb_st_t;

endpackage

//--- ihbp_timer_if.sv
`timescale 1ns/1ps
interface ihbp_timer_if;
  logic start;
  logic tick;
  logic active;
  modport ctl (output start, output tick, input active);
  modport tmr (input start, input tick, output active);
endinterface

//--- ihbp_fall_det.sv
`timescale 1ns/1ps
module ihbp_fall_det #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // strobes, active low
  input  wire logic [W-1:0] strobe_n,
  // one-cycle pulse on each falling edge
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;

  // idle strobes are high, so reset to high to avoid a false edge
  always_comb begin
    prev_nxt = strobe_n;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_r <= '1;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign fall = prev_r & ~strobe_n;

endmodule

//--- ihbp_hold_timer.sv
`timescale 1ns/1ps
module ihbp_hold_timer #(
  parameter int unsigned LEN = 2,
  parameter int unsigned W   = 16
) (
  // clock and reset
  input  wire logic     sys_clk,
  input  wire logic     rst,
  // start, tick and active
  ihbp_timer_if.tmr     t
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         act_r;
  logic         act_nxt;

  // a new start restarts the count, so the hold is never cut short
  always_comb begin
    cnt_nxt = cnt_r;
    act_nxt = act_r;
    if (t.start) begin
      cnt_nxt = W'(LEN);
      act_nxt = 1'b1;
    end else if (act_r && t.tick) begin
      cnt_nxt = cnt_r - W'(1);
      if (cnt_r == W'(1)) begin
        act_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      act_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
    end
  end

  assign t.active = act_r;

endmodule

//--- ihbp_port.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// - earlier revision: decode-mode bit is stored but never alters memory decode
// - earlier revision: one level of status; later keeps a second pending level
// - data port is one location; pointer steps two per access in 16-bit mode
// - wait bit zero never negates ready; zero-wait output stays unconnected early
// - transmit led held active at least 314 us per indication
// - later revision: width detect sampled until first config write, low means 16-bit
// - width bit reads the detected default; a software write replaces it
// - later revision: wide memory select from unlatched address 19..11, or 19..17 with decode bit clear
// - later revision: wide io select from unlatched address 15..2
// - later revision: ready negated two to three crystal periods per access
// - later revision: address captured on falling edge of memory strobes
// - with latch enable tied high, split 8-bit cycles address correctly
module ihbp_port #(
  parameter bit          LATER_REV     = 1'b1,
  parameter int unsigned XTAL_DIV      = ihbp_pkg::XTAL_DIV_DEF,
  parameter int unsigned TX_LED_CYCLES = ihbp_pkg::TX_LED_CYCLES
) (
  // clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // host expansion bus
  input  wire logic [19:0]                    host_addr,
  input  wire logic                           addr_latch_en,
  input  wire logic                           aen,
  input  wire logic                           mem_rd_n,
  input  wire logic                           mem_wr_n,
  input  wire logic                           io_rd_n,
  input  wire logic                           io_wr_n,
  input  wire logic                           width_detect_n,
  output logic                                wide_memory_select_n,
  output logic                                wide_io_select_n,
  output logic                                bus_ready,
  output logic                                zero_wait_grant_n,
  // core side
  input  wire logic [ihbp_pkg::EVT_W-1:0]     status_evt,
  input  wire logic                           tx_evt,
  output logic                                tx_led_n,
  output logic      [ihbp_pkg::RAM_PTR_W-1:0] ram_ptr
);
  import ihbp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int unsigned READY_TICKS = LATER_REV ? READY_TICKS_LATER : READY_TICKS_EARLIER;

  ihbp_apb_st_t          st_r, st_nxt;
  logic [31:0]           prdata_r, prdata_nxt;
  logic                  pslverr_r, pslverr_nxt;
  logic                  wide_r, wide_nxt;
  logic                  decode_r, decode_nxt;
  logic                  wait_r, wait_nxt;
  logic                  detect_win_r, detect_win_nxt;
  logic [MEM_BASE_W-1:0] mem_base_r, mem_base_nxt;
  logic [IO_BASE_W-1:0]  io_base_r, io_base_nxt;
  logic [RAM_PTR_W-1:0]  ptr_r, ptr_nxt;
  logic [EVT_W-1:0]      stat_r, stat_nxt;
  logic [EVT_W-1:0]      pend_r, pend_nxt;
  logic [19:0]           addr_r, addr_nxt;
  logic                  memsel_n_r, memsel_n_nxt;
  logic                  iosel_n_r, iosel_n_nxt;
  logic                  ready_r, ready_nxt;
  logic                  zws_n_r, zws_n_nxt;
  logic                  led_n_r, led_n_nxt;
  logic [15:0]           div_r, div_nxt;
  logic                  xtal_tick;

  logic                  acc_done;
  logic                  wr_done;
  logic                  rd_start;
  logic [31:0]           rd_val;
  logic                  rd_hit;
  logic [STB_N-1:0]      stb_n;
  logic [STB_N-1:0]      stb_fall;
  logic                  mem_hit_raw;
  logic                  io_hit_raw;
  logic                  mem_cycle;
  logic                  own_access;
  logic                  port_access;
  logic [EVT_W-1:0]      clr_mask;

  ihbp_timer_if ready_tif ();
  ihbp_timer_if led_tif ();

  //////////////////////////////////////////////////////////////////////////////
  // leaf instances

  assign stb_n = {io_wr_n, io_rd_n, mem_wr_n, mem_rd_n};

  ihbp_fall_det #(
    .W (STB_N)
  ) u_fall (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .strobe_n (stb_n),
    .fall     (stb_fall)
  );

  // ready hold counts crystal ticks; the start phase takes off up to one period
  ihbp_hold_timer #(
    .LEN (READY_TICKS),
    .W   (4)
  ) u_ready (
    .sys_clk (sys_clk),
    .rst     (rst),
    .t       (ready_tif)
  );

  ihbp_hold_timer #(
    .LEN (TX_LED_CYCLES),
    .W   (24)
  ) u_led (
    .sys_clk (sys_clk),
    .rst     (rst),
    .t       (led_tif)
  );

  //////////////////////////////////////////////////////////////////////////////
  // crystal period enable from the system clock

  always_comb begin
    div_nxt = div_r + 16'h0001;
    if (div_r == 16'(XTAL_DIV - 1)) begin
      div_nxt = 16'h0000;
    end
  end

  assign xtal_tick = (div_r == 16'h0000);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait cycle, write lands at the pready edge

  assign rd_start = psel && penable && (st_r == APB_IDLE);
  assign acc_done = psel && penable && (st_r == APB_ACK);
  assign wr_done  = acc_done && pwrite;

  // read mux; reserved bits are zero
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      OFS_CONFIG: begin
        rd_val[CFG_WIDE_BIT]   = wide_r;
        rd_val[CFG_DECODE_BIT] = decode_r;
        rd_val[CFG_WAIT_BIT]   = wait_r;
      end
      OFS_MEM_BASE: rd_val[MEM_BASE_W-1:0] = mem_base_r;
      OFS_IO_BASE:  rd_val[IO_BASE_W-1:0]  = io_base_r;
      OFS_RAM_PTR:  rd_val[RAM_PTR_W-1:0]  = ptr_r;
      OFS_STATUS:   rd_val[2*EVT_W-1:0]    = {pend_r, stat_r};
      OFS_ADDR:     rd_val[19:0]           = addr_r;
      default:      rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt      = st_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    case (st_r)
      APB_IDLE: begin
        if (rd_start) begin
          st_nxt      = APB_ACK;
          prdata_nxt  = pwrite ? 32'h0000_0000 : rd_val;
          pslverr_nxt = ~rd_hit;
        end
      end
      APB_ACK: begin
        st_nxt      = APB_IDLE;
        pslverr_nxt = 1'b0;
      end
      default: begin
        st_nxt      = APB_IDLE;
        pslverr_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r      <= APB_IDLE;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign pready  = (st_r == APB_ACK);
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  //////////////////////////////////////////////////////////////////////////////
  // configuration, bases, pointer and status

  assign port_access = (stb_fall[STB_IOR] || stb_fall[STB_IOW]) && io_hit_raw
                       && (host_addr[1:0] == 2'b00);
  assign clr_mask = (wr_done && paddr == OFS_STATUS) ? pwdata[EVT_W-1:0] : '0;

  always_comb begin
    wide_nxt       = wide_r;
    decode_nxt     = decode_r;
    wait_nxt       = wait_r;
    detect_win_nxt = detect_win_r;
    mem_base_nxt   = mem_base_r;
    io_base_nxt    = io_base_r;
    ptr_nxt        = ptr_r;
    // detection window stays open until the first config write
    if (LATER_REV && detect_win_r && !width_detect_n) begin
      wide_nxt = 1'b1;
    end
    // host access to the data port steps the pointer
    if (port_access) begin
      ptr_nxt = ptr_r + (wide_r ? STEP_WIDE : STEP_NARROW);
    end
    if (wr_done) begin
      case (paddr)
        OFS_CONFIG: begin
          wide_nxt       = pwdata[CFG_WIDE_BIT];
          decode_nxt     = pwdata[CFG_DECODE_BIT];
          wait_nxt       = pwdata[CFG_WAIT_BIT];
          detect_win_nxt = 1'b0;
        end
        OFS_MEM_BASE: mem_base_nxt = pwdata[MEM_BASE_W-1:0];
        OFS_IO_BASE:  io_base_nxt  = pwdata[IO_BASE_W-1:0];
        OFS_RAM_PTR:  ptr_nxt      = pwdata[RAM_PTR_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // events set, write-one clears; a set in the clear cycle wins
  always_comb begin
    stat_nxt = stat_r & ~clr_mask;
    pend_nxt = pend_r;
    if (LATER_REV) begin
      // a cleared bit reloads from its pending level
      stat_nxt = stat_nxt | (pend_r & clr_mask);
      pend_nxt = (pend_r & ~clr_mask) | (status_evt & stat_r & ~clr_mask);
    end
    // earlier revision: a second event merges into the single level
    stat_nxt = stat_nxt | status_evt;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wide_r       <= CFG_WIDE_RST;
      decode_r     <= CFG_DECODE_RST;
      wait_r       <= CFG_WAIT_RST;
      detect_win_r <= 1'b1;
      mem_base_r   <= MEM_BASE_RST;
      io_base_r    <= IO_BASE_RST;
      ptr_r        <= RAM_PTR_RST;
      stat_r       <= '0;
      pend_r       <= '0;
    end else begin
      wide_r       <= wide_nxt;
      decode_r     <= decode_nxt;
      wait_r       <= wait_nxt;
      detect_win_r <= detect_win_nxt;
      mem_base_r   <= mem_base_nxt;
      io_base_r    <= io_base_nxt;
      ptr_r        <= ptr_nxt;
      stat_r       <= stat_nxt;
      pend_r       <= pend_nxt;
    end
  end

  assign ram_ptr = ptr_r;

  //////////////////////////////////////////////////////////////////////////////
  // address capture and wide selects

  // later revision skips the latch so selects move with the raw address
  always_comb begin
    mem_hit_raw = LATER_REV ? (host_addr[19:11] == mem_base_r)
                            : (addr_r[19:11] == mem_base_r);
    if (LATER_REV && !decode_r) begin
      mem_hit_raw = (host_addr[19:17] == mem_base_r[8:6]);
    end
    io_hit_raw = !aen && (LATER_REV ? (host_addr[15:2] == io_base_r)
                                    : (addr_r[15:2] == io_base_r));
  end

  always_comb begin
    addr_nxt = addr_r;
    // only the earlier part follows the latch enable; later boards may tie it high
    if (!LATER_REV && addr_latch_en) begin
      addr_nxt = host_addr;
    end
    // memory strobes capture on their leading edge, latch enable or not
    if (LATER_REV && (stb_fall[STB_MEMR] || stb_fall[STB_MEMW])) begin
      addr_nxt = host_addr;
    end
    memsel_n_nxt = ~mem_hit_raw;
    iosel_n_nxt  = ~io_hit_raw;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_r     <= 20'h00000;
      memsel_n_r <= 1'b1;
      iosel_n_r  <= 1'b1;
    end else begin
      addr_r     <= addr_nxt;
      memsel_n_r <= memsel_n_nxt;
      iosel_n_r  <= iosel_n_nxt;
    end
  end

  assign wide_memory_select_n = memsel_n_r;
  assign wide_io_select_n     = iosel_n_r;

  //////////////////////////////////////////////////////////////////////////////
  // ready negation, zero-wait grant and transmit led

  assign mem_cycle  = !mem_rd_n || !mem_wr_n;
  assign own_access = ((stb_fall[STB_MEMR] || stb_fall[STB_MEMW]) && mem_hit_raw)
                      || ((stb_fall[STB_IOR] || stb_fall[STB_IOW]) && io_hit_raw);

  assign ready_tif.start = own_access && wait_r;
  assign ready_tif.tick  = xtal_tick;
  assign led_tif.start   = tx_evt;
  assign led_tif.tick    = 1'b1;

  always_comb begin
    ready_nxt = ~ready_tif.active;
    // the earlier grant fires on any memory cycle, so boards leave it open
    zws_n_nxt = LATER_REV ? ~(mem_cycle && mem_hit_raw && !wait_r)
                          : ~mem_cycle;
    led_n_nxt = ~led_tif.active;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ready_r <= 1'b1;
      zws_n_r <= 1'b1;
      led_n_r <= 1'b1;
    end else begin
      ready_r <= ready_nxt;
      zws_n_r <= zws_n_nxt;
      led_n_r <= led_n_nxt;
    end
  end

  assign bus_ready         = ready_r;
  assign zero_wait_grant_n = zws_n_r;
  assign tx_led_n          = led_n_r;

endmodule

//--- ihbp_port_asserts.sv
`timescale 1ns/1ps
module ihbp_port_asserts #(
  parameter int unsigned TX_LED_CYCLES = 20
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // host bus
  input wire logic [19:0] host_addr,
  input wire logic        aen,
  input wire logic        mem_rd_n,
  input wire logic        mem_wr_n,
  input wire logic        wide_memory_select_n,
  input wire logic        wide_io_select_n,
  input wire logic        bus_ready,
  input wire logic        zero_wait_grant_n,
  // core side
  input wire logic        tx_evt,
  input wire logic        tx_led_n
);
  import ihbp_pkg::*;
  logic [8:0]  mb_r;
  logic [13:0] iob_r;
  logic        dec_r, wt_r, mhit_r, ihit_r, mstb_r, wr_ok;
  logic [15:0] led_r;
  assign wr_ok = psel & penable & pready & pwrite;
  ////////////////////////////////////////
  // shadow the decode settings from completed writes; hits lag a cycle like the selects
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mb_r   <= MEM_BASE_RST;
      iob_r  <= IO_BASE_RST;
      dec_r  <= CFG_DECODE_RST;
      wt_r   <= CFG_WAIT_RST;
      mhit_r <= 1'b0;
      ihit_r <= 1'b0;
      mstb_r <= 1'b0;
      led_r  <= 16'h0000;
    end else begin
      if (wr_ok && paddr == OFS_CONFIG) begin
        dec_r <= pwdata[CFG_DECODE_BIT];
        wt_r  <= pwdata[CFG_WAIT_BIT];
      end
      if (wr_ok && paddr == OFS_MEM_BASE) mb_r <= pwdata[8:0];
      if (wr_ok && paddr == OFS_IO_BASE) iob_r <= pwdata[13:0];
      mhit_r <= dec_r ? host_addr[19:11] == mb_r : host_addr[19:17] == mb_r[8:6];
      ihit_r <= host_addr[15:2] == iob_r && !aen;
      mstb_r <= !(mem_rd_n && mem_wr_n);
      led_r  <= tx_led_n ? 16'h0000 : led_r + 16'h0001;  // low-time counter
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // selects follow the raw decode exactly, one cycle behind the address
  mem_sel_a: assert property (wide_memory_select_n != mhit_r)
    else $error("memory select without a hit");
  io_sel_a: assert property (wide_io_select_n != ihit_r)
    else $error("io select without a hit");
  ready_neg_a: assert property ($fell(mem_rd_n) && !wide_memory_select_n && wt_r
    |-> ##[2:3] !bus_ready) else $error("ready not negated");
  ready_len_a: assert property ($fell(bus_ready) |-> !bus_ready[*4] ##[1:4] bus_ready)
    else $error("ready low length off");
  no_wait_a: assert property ($fell(bus_ready) |-> wt_r)
    else $error("ready negated with wait bit clear");
  zws_own_a: assert property (!zero_wait_grant_n |-> mstb_r && !wt_r)
    else $error("zero wait grant without cause");
  led_on_a: assert property ($rose(tx_evt) |-> ##[1:2] !tx_led_n)
    else $error("led not lit");
  led_len_a: assert property ($rose(tx_led_n) |-> int'(led_r) >= TX_LED_CYCLES)
    else $error("led pulse short");
  cover property ($fell(bus_ready));
  cover property (!zero_wait_grant_n);
  cover property ($rose(tx_led_n));
endmodule

bind ihbp_port ihbp_port_asserts #(.TX_LED_CYCLES(TX_LED_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .host_addr(host_addr), .aen(aen),
  .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n), .wide_memory_select_n(wide_memory_select_n),
  .wide_io_select_n(wide_io_select_n), .bus_ready(bus_ready),
  .zero_wait_grant_n(zero_wait_grant_n), .tx_evt(tx_evt), .tx_led_n(tx_led_n)
);

//--- ihbp_host_model.sv
`timescale 1ns/1ps
module ihbp_host_model (
  // clock and ready
  input  wire logic   sys_clk,
  input  wire logic   bus_ready,
  // host bus
  output logic [19:0] host_addr,
  output logic        addr_latch_en,
  output logic        aen,
  output logic [3:0]  stb_n
);
  logic ale_tied = 1'b0;  // board ties latch enable high in 8-bit mode
  initial begin
    host_addr = 20'h00000;
    addr_latch_en = 1'b0;
    aen = 1'b0;
    stb_n = 4'hF;
  end
  ////////////////////////////////////////
  // address and dma flag only, latch enable left alone, as between cycles
  task automatic put_addr(input logic [19:0] a, input logic dma);
    @(posedge sys_clk);
    host_addr <= a;
    aen <= dma;
  endtask
  // one strobe cycle to the given address, odd byte addresses included
  task automatic cycle(input logic [19:0] a, input int s);
    int n;
    @(posedge sys_clk);
    host_addr <= a;
    aen <= 1'b0;
    addr_latch_en <= 1'b1;
    @(posedge sys_clk);
    addr_latch_en <= ale_tied;
    stb_n[s] <= 1'b0;
    n = 0;
    repeat (4) @(posedge sys_clk);
    // hold the strobe while the device stretches the cycle
    while (bus_ready !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    stb_n[s] <= 1'b1;
    host_addr <= ~a;  // the old address does not linger after release
    if (n >= 40) begin
      tb.num_errors++;
      tb.conclude();
    end
  endtask
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
  import ihbp_pkg::*;
  localparam int LEDC = 20;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic        aen, addr_latch_en, width_detect_n, tx_evt, tx_led_n;
  logic        bus_ready, zws_n, msel_n, isel_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [19:0] host_addr;
  logic [3:0]  stb_n;
  logic [1:0]  status_evt;
  logic [10:0] ram_ptr;
  int          num_errors, check_count, low_cnt, zws_cnt;
  ihbp_port #(.LATER_REV(1'b1), .XTAL_DIV(2), .TX_LED_CYCLES(LEDC)) dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_addr(host_addr), .addr_latch_en(addr_latch_en), .aen(aen),
    .mem_rd_n(stb_n[STB_MEMR]), .mem_wr_n(stb_n[STB_MEMW]), .io_rd_n(stb_n[STB_IOR]),
    .io_wr_n(stb_n[STB_IOW]), .width_detect_n(width_detect_n),
    .wide_memory_select_n(msel_n), .wide_io_select_n(isel_n), .bus_ready(bus_ready),
    .zero_wait_grant_n(zws_n), .status_evt(status_evt), .tx_evt(tx_evt),
    .tx_led_n(tx_led_n), .ram_ptr(ram_ptr));
  ihbp_host_model host (.sys_clk(sys_clk), .bus_ready(bus_ready), .host_addr(host_addr),
    .addr_latch_en(addr_latch_en), .aen(aen), .stb_n(stb_n));
  always #5 sys_clk = ~sys_clk;
  // running counts of wait and grant cycles; scenarios compare snapshots
  always @(posedge sys_clk) begin
    if (!bus_ready) low_cnt++;
    if (!zws_n) zws_cnt++;
  end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask
  task automatic do_reset(input logic det);
    width_detect_n <= det;
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    width_detect_n <= 1'b1;
  endtask
  task automatic pulse(input logic [1:0] v);
    @(posedge sys_clk);
    status_evt <= v;
    @(posedge sys_clk);
    status_evt <= 2'h0;
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    rchk("config", OFS_CONFIG, 32'h10);
    rchk("mem base", OFS_MEM_BASE, 32'h1A0);
    rchk("io base", OFS_IO_BASE, 32'hB8);
    rchk("ptr reg", OFS_RAM_PTR, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    $display("test regs done");
  endtask
  task automatic t_width();
    do_reset(1'b0);
    rchk("config wide", OFS_CONFIG, 32'h90);
    apb(1'b1, OFS_CONFIG, 32'h10);
    rchk("config over", OFS_CONFIG, 32'h10);
    width_detect_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    width_detect_n <= 1'b1;
    rchk("config kept", OFS_CONFIG, 32'h10);
    $display("test width done");
  endtask
  // decode table: mode, address, io or memory, dma flag, expected select
  task automatic t_decode();
    logic [19:0] a [9] = '{20'hC0000, 20'hE0000, 20'hC0000, 20'hD07FF, 20'hD0800,
                            20'h002E0, 20'h002E0, 20'h002E4, 20'h002E3};
    logic [0:8] dec = 9'b001111111;
    logic [0:8] io = 9'b000001111;
    logic [0:8] dma = 9'b000000100;
    logic [0:8] exp = 9'b011010110;
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, OFS_CONFIG, {24'h0, 2'b10, dec[i], 5'h10});
      host.put_addr(a[i], dma[i]);
      repeat (2) @(posedge sys_clk);
      chk("select", {31'h0, exp[i]}, {31'h0, io[i] ? isel_n : msel_n});
    end
    $display("test decode done");
  endtask
  task automatic t_wait();
    int c;
    apb(1'b1, OFS_CONFIG, 32'hB0);
    c = low_cnt;
    host.cycle(20'hD0123, STB_MEMR);
    chk("ready low", 32'h1, {31'h0, (low_cnt - c) inside {[4:6]}});
    rchk("addr rd", OFS_ADDR, 32'hD0123);
    host.cycle(20'hD0456, STB_MEMW);
    rchk("addr wr", OFS_ADDR, 32'hD0456);
    apb(1'b1, OFS_CONFIG, 32'h30);
    host.ale_tied = 1'b1;
    host.cycle(20'hD0200, STB_MEMR);
    rchk("addr lo", OFS_ADDR, 32'hD0200);
    host.cycle(20'hD0201, STB_MEMR);
    rchk("addr hi", OFS_ADDR, 32'hD0201);
    host.ale_tied = 1'b0;
    $display("test wait done");
  endtask
  task automatic t_nowait();
    int c;
    int z;
    apb(1'b1, OFS_CONFIG, 32'hA0);
    c = low_cnt;
    z = zws_cnt;
    host.cycle(20'hE0000, STB_MEMR);
    chk("zws foreign", z, zws_cnt);
    host.cycle(20'hD0010, STB_MEMR);
    chk("ready kept", c, low_cnt);
    chk("zws own", 32'h1, {31'h0, zws_cnt > z});
    $display("test nowait done");
  endtask
  task automatic t_ptr();
    apb(1'b1, OFS_CONFIG, 32'hB0);
    apb(1'b1, OFS_RAM_PTR, 32'h7FE);
    host.cycle(20'h002E0, STB_IOR);
    chk("ptr wrap", 32'h0, {21'h0, ram_ptr});
    host.cycle(20'h002E0, STB_IOW);
    chk("ptr two", 32'h2, {21'h0, ram_ptr});
    apb(1'b1, OFS_CONFIG, 32'h30);
    host.cycle(20'h002E0, STB_IOR);
    chk("ptr one", 32'h3, {21'h0, ram_ptr});
    host.cycle(20'h002E2, STB_IOR);
    chk("ptr odd", 32'h3, {21'h0, ram_ptr});
    $display("test ptr done");
  endtask
  task automatic t_status();
    pulse(2'b01);
    rchk("st one", OFS_STATUS, 32'h1);
    pulse(2'b01);
    rchk("st pend", OFS_STATUS, 32'h5);
    apb(1'b1, OFS_STATUS, 32'h1);
    rchk("st reload", OFS_STATUS, 32'h1);
    apb(1'b1, OFS_STATUS, 32'h1);
    pulse(2'b10);
    rchk("st two", OFS_STATUS, 32'h2);
    $display("test status done");
  endtask
  task automatic t_led();
    int n;
    int m;
    @(posedge sys_clk);
    tx_evt <= 1'b1;
    @(posedge sys_clk);
    tx_evt <= 1'b0;
    n = 0;
    m = 0;
    while (tx_led_n !== 1'b0 && n < 10) begin
      @(posedge sys_clk);
      n++;
    end
    while (tx_led_n === 1'b0 && m < 200) begin
      @(posedge sys_clk);
      m++;
    end
    chk("led width", LEDC, m);
    $display("test led done");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, tx_evt} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    width_detect_n = 1'b1;
    status_evt = 2'h0;
    do_reset(1'b1);
    t_regs();
    t_width();
    t_decode();
    t_wait();
    t_nowait();
    t_ptr();
    t_status();
    t_led();
    conclude();
  end
endmodule
